// *** bench/ioiu_card_model.sv ***
`timescale 1ns/10ps
module ioiu_card_model (
  // Clock and bench command
  input  wire logic        clk_in,
  input  wire logic [63:0] ready_cmd_in,
  // Design side
  input  wire logic [5:0]  sel_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] wr_data_in,
  output logic      [63:0] ready_out,
  output logic      [15:0] rd_data_out
);
  logic [15:0] buf_q [64];
  logic [5:0]  sel_q;

  initial
  begin
    for (int i = 0; i < 64; i++)
      buf_q[i] = 16'h5A00 ^ 16'(i);
  end

  ////////////////////////////////////////////////////////////////
  assign ready_out = ready_cmd_in;
  assign rd_data_out = buf_q[sel_in];

  always @(posedge clk_in)
  begin
    sel_q <= sel_in;
    if (wr_in)
      buf_q[sel_q] <= wr_data_in;
  end
endmodule

// *** bench/ioiu_tb_top.sv ***
`timescale 1ns/10ps
module ioiu_tb_top;
  logic                   clk, rst_n, valid, ack, svc_end, rwr, rrd, b;
  logic [15:0]            word, acc_a, acc_b, dev_rd, rnd, exp_v, halt_word, dev_wdata;
  logic [14:0]            pc, halt_pc;
  logic [63:0]            ready_cmd, dev_ready, dev_ctrl;
  logic [2:0]             raddr;
  logic [31:0]            rwdata, rdata, reg_rdata;
  logic [5:0]             d, irq_code, dev_sel;
  logic                   done, skip, halt, irq, dev_wr, s_done, s_skip, s_wr;
  ioiu_pkg::ioiu_acc_wr_t acc_wr, s_acc;
  int                     errors, n_tests, cycles;

  ioiu_top i_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid), .INSTR_WORD_IN(word),
    .INSTR_PC_IN(pc), .ACC_A_IN(acc_a), .ACC_B_IN(acc_b), .DONE_OUT(done), .SKIP_OUT(skip),
    .ACC_WR_OUT(acc_wr), .HALT_OUT(halt), .HALT_WORD_OUT(halt_word), .HALT_PC_OUT(halt_pc),
    .IRQ_REQ_OUT(irq), .IRQ_CODE_OUT(irq_code), .IRQ_ACK_IN(ack), .SVC_END_IN(svc_end),
    .DEV_READY_IN(dev_ready), .DEV_CTRL_OUT(dev_ctrl), .DEV_SEL_OUT(dev_sel), .DEV_RD_DATA_IN(dev_rd),
    .DEV_WR_OUT(dev_wr), .DEV_WR_DATA_OUT(dev_wdata), .REG_ADDR_IN(raddr), .REG_WR_DATA_IN(rwdata),
    .REG_WR_IN(rwr), .REG_RD_IN(rrd), .REG_RD_DATA_OUT(reg_rdata));
  ioiu_card_model i_card (.clk_in(clk), .ready_cmd_in(ready_cmd), .sel_in(dev_sel), .wr_in(dev_wr),
    .wr_data_in(dev_wdata), .ready_out(dev_ready), .rd_data_out(dev_rd));

  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] mk(input logic ab, input logic c, input logic [2:0] op, input logic [5:0] s);
    return {ioiu_pkg::GRP_IO, ab, 1'b1, c, op, s};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      errors++;
    end
  endtask
  task automatic instr(input logic [15:0] w, input logic [15:0] a, input logic [15:0] bb);
    @(posedge clk);
    valid <= 1'b1;
    word <= w;
    acc_a <= a;
    acc_b <= bb;
    pc <= a[14:0];
    @(posedge clk);
    valid <= 1'b0;
    #1;
    s_done = done;
    s_skip = skip;
    s_acc = acc_wr;
    s_wr = dev_wr;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    rrd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    rdata = reg_rdata;
  endtask
  task automatic wait_irq(input logic [5:0] c);
    for (int i = 0; i < 6 && irq !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irq", {25'h0, 1'b1, c}, {25'h0, irq, irq_code});
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask
  task automatic results();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    {rst_n, valid, ack, svc_end, rwr, rrd, word, acc_a, acc_b, pc, ready_cmd, raddr, rwdata} = '0;
    rnd = 16'h8993;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset state and unmapped read
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(3'(a));
      chk("reg after reset", 32'h0000_0000, rdata);
    end
    instr(16'h8005, 16'h0000, 16'h0000);
    chk("macro done", 1, {31'h0, s_done});
    chk("macro acc", 0, {31'h0, s_acc.we});
    // Random data moves
    repeat (8)
    begin
      rnd = lfsr(rnd);
      d = 6'(2 + rnd % 30);
      b = rnd[0];
      exp_v = b ? ~rnd : rnd;
      instr(mk(b, 1'b0, ioiu_pkg::OP_OUTPUT, d), rnd, ~rnd);
      chk("output strobe", 1, {31'h0, s_wr});
      chk("output data", {16'h0, exp_v}, {16'h0, dev_wdata});
      instr(mk(~b, 1'b0, ioiu_pkg::OP_LOAD, d), 16'h0000, 16'h0000);
      chk("load", {14'h0, 1'b1, ~b, exp_v}, 32'(s_acc));
      instr(mk(b, 1'b0, ioiu_pkg::OP_MERGE, d), 16'h0F0F, 16'h0F0F);
      chk("merge", {14'h0, 1'b1, b, exp_v | 16'h0F0F}, 32'(s_acc));
    end
    // Control bits
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_CONTROL, d), 16'h0000, 16'h0000);
    chk("ctrl set", 1, {31'h0, dev_ctrl[d]});
    instr(mk(1'b1, 1'b0, ioiu_pkg::OP_CONTROL, d), 16'h0000, 16'h0000);
    chk("ctrl clr", 0, {31'h0, dev_ctrl[d]});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_CONTROL, 6'h28), 16'h0000, 16'h0000);
    instr(mk(1'b1, 1'b0, ioiu_pkg::OP_CONTROL, 6'h00), 16'h0000, 16'h0000);
    chk("ctrl all", 0, {31'h0, |dev_ctrl});
    // Overflow set, skips and clear
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_FLAG, ioiu_pkg::SEL_OVERFLOW), 16'h0000, 16'h0000);
    rd_reg(ioiu_pkg::REG_STATUS);
    chk("ovf set", 1, {31'h0, rdata[ioiu_pkg::ST_OVF]});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_SKIP_CLR, ioiu_pkg::SEL_OVERFLOW), 16'h0000, 16'h0000);
    chk("soc set", 0, {31'h0, s_skip});
    instr(mk(1'b0, 1'b1, ioiu_pkg::OP_SKIP_SET, ioiu_pkg::SEL_OVERFLOW), 16'h0000, 16'h0000);
    chk("sos clr", 1, {31'h0, s_skip});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_SKIP_CLR, ioiu_pkg::SEL_OVERFLOW), 16'h0000, 16'h0000);
    chk("soc clear", 1, {31'h0, s_skip});
    // Flags from a ready card
    @(posedge clk);
    ready_cmd[d] <= 1'b1;
    repeat (8) @(posedge clk);
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_SKIP_SET, d), 16'h0000, 16'h0000);
    chk("flag ready", 1, {31'h0, s_skip});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_SKIP_SET, d + 6'h1), 16'h0000, 16'h0000);
    chk("other flag", 0, {31'h0, s_skip});
    instr(mk(1'b0, 1'b1, ioiu_pkg::OP_FLAG, d), 16'h0000, 16'h0000);
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_SKIP_CLR, d), 16'h0000, 16'h0000);
    chk("flag clr", 1, {31'h0, s_skip});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_FLAG, d), 16'h0000, 16'h0000);
    instr(mk(1'b0, 1'b1, ioiu_pkg::OP_SKIP_SET, d), 16'h0000, 16'h0000);
    chk("stf skip", 1, {31'h0, s_skip});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_SKIP_CLR, d), 16'h0000, 16'h0000);
    chk("bit9 clr", 1, {31'h0, s_skip});
    // Interrupts with nesting
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_FLAG, ioiu_pkg::SEL_IRQ_SYS), 16'h0000, 16'h0000);
    rd_reg(ioiu_pkg::REG_STATUS);
    chk("ien on", 1, {31'h0, rdata[ioiu_pkg::ST_IEN]});
    for (int k = 0; k < 2; k++)
    begin
      instr(mk(1'b0, 1'b0, ioiu_pkg::OP_CONTROL, d - 6'(k)), 16'h0000, 16'h0000);
      instr(mk(1'b0, 1'b0, ioiu_pkg::OP_FLAG, d - 6'(k)), 16'h0000, 16'h0000);
      wait_irq(d - 6'(k));
    end
    repeat (2)
    begin
      @(posedge clk);
      svc_end <= 1'b1;
      @(posedge clk);
      svc_end <= 1'b0;
    end
    rd_reg(ioiu_pkg::REG_SVC_LO);
    chk("in service", 0, rdata);
    instr(mk(1'b0, 1'b1, ioiu_pkg::OP_FLAG, ioiu_pkg::SEL_IRQ_SYS), 16'h0000, 16'h0000);
    rd_reg(ioiu_pkg::REG_STATUS);
    chk("ien off", 0, {31'h0, rdata[ioiu_pkg::ST_IEN]});
    rd_reg(ioiu_pkg::REG_FLAG_LO);
    chk("flags kept", 1, {31'h0, rdata[d]});
    // Halt, refused instruction, resume
    rnd = lfsr(rnd);
    instr(mk(1'b0, 1'b1, ioiu_pkg::OP_HALT, d), rnd, 16'h0000);
    chk("halt", 1, {31'h0, halt});
    chk("halt pc", {17'h0, rnd[14:0] + 15'h1}, {17'h0, halt_pc});
    chk("halt word", {16'h0, mk(1'b0, 1'b1, ioiu_pkg::OP_HALT, d)}, {16'h0, halt_word});
    instr(mk(1'b0, 1'b0, ioiu_pkg::OP_FLAG, d), 16'h0000, 16'h0000);
    chk("halted done", 0, {31'h0, s_done});
    rd_reg(ioiu_pkg::REG_FLAG_LO);
    chk("halt flag clr", 0, {31'h0, rdata[d]});
    @(posedge clk);
    rwr <= 1'b1;
    rwdata <= 32'h0000_0001;
    raddr <= ioiu_pkg::REG_STATUS;
    @(posedge clk);
    rwr <= 1'b0;
    rd_reg(ioiu_pkg::REG_STATUS);
    chk("resumed", 0, {31'h0, rdata[ioiu_pkg::ST_HALTED]});
    results();
  end
endmodule

// *** bench/ioiu_top_sva.sv ***
`timescale 1ns/10ps
module ioiu_top_sva (
  input wire logic                         CLK_SYS_IN,
  input wire logic                         RST_N_IN,
  input wire logic                         INSTR_VALID_IN,
  input wire logic [15:0]                  INSTR_WORD_IN,
  input wire logic [14:0]                  INSTR_PC_IN,
  input wire logic [15:0]                  ACC_A_IN,
  input wire logic [15:0]                  ACC_B_IN,
  input wire logic                         DONE_OUT,
  input wire logic                         SKIP_OUT,
  input wire ioiu_pkg::ioiu_acc_wr_t       ACC_WR_OUT,
  input wire logic                         HALT_OUT,
  input wire logic [15:0]                  HALT_WORD_OUT,
  input wire logic [14:0]                  HALT_PC_OUT,
  input wire logic                         IRQ_REQ_OUT,
  input wire logic [5:0]                   IRQ_CODE_OUT,
  input wire logic                         IRQ_ACK_IN,
  input wire logic [63:0]                  DEV_CTRL_OUT,
  input wire logic [5:0]                   DEV_SEL_OUT,
  input wire logic [15:0]                  DEV_RD_DATA_IN,
  input wire logic                         DEV_WR_OUT,
  input wire logic [15:0]                  DEV_WR_DATA_OUT
);
  logic        io_v;
  logic        mac_v;
  logic [2:0]  op;
  logic [15:0] acc_sel;

  assign io_v = INSTR_VALID_IN && !HALT_OUT && INSTR_WORD_IN[15:12] == ioiu_pkg::GRP_IO && INSTR_WORD_IN[10];
  assign mac_v = INSTR_VALID_IN && !HALT_OUT && INSTR_WORD_IN[15:12] == ioiu_pkg::GRP_IO && !INSTR_WORD_IN[10];
  assign op = INSTR_WORD_IN[8:6];
  assign acc_sel = INSTR_WORD_IN[11] ? ACC_B_IN : ACC_A_IN;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  ////////////////////////////////////////////////////////////////
  property p_done;
    INSTR_VALID_IN && !HALT_OUT |=> DONE_OUT;
  endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_done_cause;
    DONE_OUT |-> $past(INSTR_VALID_IN);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without instruction");
  property p_load;
    io_v && op == ioiu_pkg::OP_LOAD |=> ACC_WR_OUT.we && ACC_WR_OUT.sel_b == $past(INSTR_WORD_IN[11])
      && ACC_WR_OUT.data == $past(DEV_RD_DATA_IN);
  endproperty
  a_load: assert property (p_load) else $error("load result wrong");
  property p_merge;
    io_v && op == ioiu_pkg::OP_MERGE |=> ACC_WR_OUT.we && ACC_WR_OUT.data == ($past(DEV_RD_DATA_IN) | $past(acc_sel));
  endproperty
  a_merge: assert property (p_merge) else $error("merge result wrong");
  property p_output;
    io_v && op == ioiu_pkg::OP_OUTPUT |=> DEV_WR_OUT && !ACC_WR_OUT.we && DEV_WR_DATA_OUT == $past(acc_sel);
  endproperty
  a_output: assert property (p_output) else $error("output transfer wrong");
  property p_halt;
    io_v && op == ioiu_pkg::OP_HALT |=> HALT_OUT && HALT_WORD_OUT == $past(INSTR_WORD_IN)
      && HALT_PC_OUT == $past(INSTR_PC_IN) + 15'h1;
  endproperty
  a_halt: assert property (p_halt) else $error("halt state wrong");
  property p_halt_quiet;
    HALT_OUT |-> !IRQ_REQ_OUT;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("interrupt while halted");
  property p_macro;
    mac_v |=> DONE_OUT && !SKIP_OUT && !ACC_WR_OUT.we && !DEV_WR_OUT && $stable(DEV_CTRL_OUT);
  endproperty
  a_macro: assert property (p_macro) else $error("macro entry acted");
  property p_boundary;
    INSTR_VALID_IN || DONE_OUT |=> !IRQ_REQ_OUT;
  endproperty
  a_boundary: assert property (p_boundary) else $error("request inside a phase");
  property p_irq_ctrl;
    IRQ_REQ_OUT |-> DEV_CTRL_OUT[IRQ_CODE_OUT];
  endproperty
  a_irq_ctrl: assert property (p_irq_ctrl) else $error("request without control");
  property p_ack;
    IRQ_ACK_IN && IRQ_REQ_OUT |=> !IRQ_REQ_OUT;
  endproperty
  a_ack: assert property (p_ack) else $error("request after grant");
  property p_sel;
    INSTR_VALID_IN |-> DEV_SEL_OUT == INSTR_WORD_IN[5:0];
  endproperty
  a_sel: assert property (p_sel) else $error("select code wrong");
endmodule

bind ioiu_top ioiu_top_sva i_sva (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
  .INSTR_WORD_IN(INSTR_WORD_IN), .INSTR_PC_IN(INSTR_PC_IN), .ACC_A_IN(ACC_A_IN), .ACC_B_IN(ACC_B_IN),
  .DONE_OUT(DONE_OUT), .SKIP_OUT(SKIP_OUT), .ACC_WR_OUT(ACC_WR_OUT), .HALT_OUT(HALT_OUT),
  .HALT_WORD_OUT(HALT_WORD_OUT), .HALT_PC_OUT(HALT_PC_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT),
  .IRQ_CODE_OUT(IRQ_CODE_OUT), .IRQ_ACK_IN(IRQ_ACK_IN), .DEV_CTRL_OUT(DEV_CTRL_OUT), .DEV_SEL_OUT(DEV_SEL_OUT),
  .DEV_RD_DATA_IN(DEV_RD_DATA_IN), .DEV_WR_OUT(DEV_WR_OUT), .DEV_WR_DATA_OUT(DEV_WR_DATA_OUT));

// *** logic/ioiu_pkg.sv ***
package ioiu_pkg;

  // Instruction word layout
  localparam int WORD_W     = 16;
  localparam int SEL_W      = 6;
  localparam int OP_W       = 3;
  localparam int GRP_W      = 4;
  localparam int PC_W       = 15;
  localparam int NUM_DEV    = 64;
  localparam int REG_DATA_W = 32;
  localparam int REG_ADDR_W = 3;

  localparam logic [GRP_W-1:0] GRP_IO = 4'h8;

  // Operation field codes
  localparam logic [OP_W-1:0] OP_HALT     = 3'h0;
  localparam logic [OP_W-1:0] OP_FLAG     = 3'h1;
  localparam logic [OP_W-1:0] OP_SKIP_CLR = 3'h2;
  localparam logic [OP_W-1:0] OP_SKIP_SET = 3'h3;
  localparam logic [OP_W-1:0] OP_MERGE    = 3'h4;
  localparam logic [OP_W-1:0] OP_LOAD     = 3'h5;
  localparam logic [OP_W-1:0] OP_OUTPUT   = 3'h6;
  localparam logic [OP_W-1:0] OP_CONTROL  = 3'h7;

  // Special select codes
  localparam logic [SEL_W-1:0] SEL_IRQ_SYS  = 6'h00;
  localparam logic [SEL_W-1:0] SEL_OVERFLOW = 6'h01;
  localparam int               FIRST_DEV    = 2;

  // Register map
  localparam logic [REG_ADDR_W-1:0] REG_STATUS  = 3'h0;
  localparam logic [REG_ADDR_W-1:0] REG_FLAG_LO = 3'h1;
  localparam logic [REG_ADDR_W-1:0] REG_FLAG_HI = 3'h2;
  localparam logic [REG_ADDR_W-1:0] REG_CTL_LO  = 3'h3;
  localparam logic [REG_ADDR_W-1:0] REG_CTL_HI  = 3'h4;
  localparam logic [REG_ADDR_W-1:0] REG_SVC_LO  = 3'h5;
  localparam logic [REG_ADDR_W-1:0] REG_SVC_HI  = 3'h6;

  // Status register bits
  localparam int ST_HALTED = 0;
  localparam int ST_IEN    = 1;
  localparam int ST_OVF    = 2;
  localparam int CMD_RUN   = 0;

  typedef struct packed {
    logic [GRP_W-1:0] grp;
    logic             acc_b;
    logic             std_io;
    logic             clr;
    logic [OP_W-1:0]  op;
    logic [SEL_W-1:0] sel;
  } ioiu_instr_t;

  typedef struct packed {
    logic              we;
    logic              sel_b;
    logic [WORD_W-1:0] data;
  } ioiu_acc_wr_t;

  typedef enum logic {
    RUNNING,
    HALTED
  } ioiu_run_t;

endpackage

// *** logic/ioiu_prio_enc.sv ***
`timescale 1ns/10ps
module ioiu_prio_enc #(
  parameter int WIDTH = 64,
  parameter int IDX_W = 6
) (
  // Request vector
  input  wire logic [WIDTH-1:0] req_in,
  // Lowest set index
  output logic                  valid_out,
  output logic [IDX_W-1:0]      idx_out
);

  always_comb
  begin
    valid_out = 1'b0;
    idx_out   = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        valid_out = 1'b1;
        idx_out   = IDX_W'(i);
      end
    end
  end

endmodule

// *** logic/ioiu_top.sv ***
// Operation
// - Group 1000 words: bit 10 one is standard I/O, zero is macro entry.
// - Low six bits select the device; only that device is touched, except by clear control with code 00.
// - Bit 9 holds or clears the device flag; overflow for overflow skips.
// - Bit 11 picks accumulator A or B for data moves; for control it picks set or clear.
// - Every I/O instruction completes in one phase.
// - Macro entry word is a no-operation.
// - Halt stops the processor and holds or clears the device flag.
// - While halted: indicator lit, panel enabled, no interrupts.
// - Halt shows the halt word and halt location plus one.
// - Set flag raises the flag; interrupt next phase if enabled and controlled.
// - Set flag with code 00 enables the interrupt system.
// - Clear flag clears the flag; code 00 disables interrupts only.
// - Skip on flag clear or flag set of the selected device.
// - Merge ORs the device buffer into the accumulator.
// - Load replaces the accumulator with the device buffer.
// - Output copies the accumulator into the device buffer, low bits.
// - Set control starts the device and lets its flag interrupt.
// - Clear control blocks interrupts; code 00 clears all control bits.
// - Set and clear overflow with code 01; overflow is sticky.
// - Overflow skips test overflow, then hold or clear it by bit 9.
// - Granted interrupt vectors to a location given by the select code.
// - Priority network orders requests and allows higher-priority nesting.
`timescale 1ns/10ps
module ioiu_top (
  // Clock and reset
  input  wire logic                              CLK_SYS_IN,
  input  wire logic                              RST_N_IN,
  // Instruction sequencer
  input  wire logic                              INSTR_VALID_IN,
  input  wire logic [ioiu_pkg::WORD_W-1:0]       INSTR_WORD_IN,
  input  wire logic [ioiu_pkg::PC_W-1:0]         INSTR_PC_IN,
  input  wire logic [ioiu_pkg::WORD_W-1:0]       ACC_A_IN,
  input  wire logic [ioiu_pkg::WORD_W-1:0]       ACC_B_IN,
  output logic                                   DONE_OUT,
  output logic                                   SKIP_OUT,
  output ioiu_pkg::ioiu_acc_wr_t                 ACC_WR_OUT,
  // Halt and front panel
  output logic                                   HALT_OUT,
  output logic [ioiu_pkg::WORD_W-1:0]            HALT_WORD_OUT,
  output logic [ioiu_pkg::PC_W-1:0]              HALT_PC_OUT,
  // Interrupt to sequencer
  output logic                                   IRQ_REQ_OUT,
  output logic [ioiu_pkg::SEL_W-1:0]             IRQ_CODE_OUT,
  input  wire logic                              IRQ_ACK_IN,
  input  wire logic                              SVC_END_IN,
  // Interface cards
  input  wire logic [ioiu_pkg::NUM_DEV-1:0]      DEV_READY_IN,
  output logic [ioiu_pkg::NUM_DEV-1:0]           DEV_CTRL_OUT,
  output logic [ioiu_pkg::SEL_W-1:0]             DEV_SEL_OUT,
  input  wire logic [ioiu_pkg::WORD_W-1:0]       DEV_RD_DATA_IN,
  output logic                                   DEV_WR_OUT,
  output logic [ioiu_pkg::WORD_W-1:0]            DEV_WR_DATA_OUT,
  // Register port
  input  wire logic [ioiu_pkg::REG_ADDR_W-1:0]   REG_ADDR_IN,
  input  wire logic [ioiu_pkg::REG_DATA_W-1:0]   REG_WR_DATA_IN,
  input  wire logic                              REG_WR_IN,
  input  wire logic                              REG_RD_IN,
  output logic [ioiu_pkg::REG_DATA_W-1:0]        REG_RD_DATA_OUT
);

  localparam int ND = ioiu_pkg::NUM_DEV;
  localparam int HW = ioiu_pkg::REG_DATA_W;

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  ioiu_pkg::ioiu_instr_t instr;
  ioiu_pkg::ioiu_run_t   run_q;
  logic                  is_io;
  logic                  is_std;
  logic                  sel_sys;
  logic                  sel_ovf;
  logic [ND-1:0]         sel_hot;
  logic [ioiu_pkg::WORD_W-1:0] acc_sel;

  assign instr   = ioiu_pkg::ioiu_instr_t'(INSTR_WORD_IN);
  assign is_io   = INSTR_VALID_IN && (instr.grp == ioiu_pkg::GRP_IO) && (run_q == ioiu_pkg::RUNNING);
  assign is_std  = is_io && instr.std_io;
  assign sel_sys = (instr.sel == ioiu_pkg::SEL_IRQ_SYS);
  assign sel_ovf = (instr.sel == ioiu_pkg::SEL_OVERFLOW);
  assign sel_hot = ND'(1) << instr.sel;
  assign acc_sel = instr.acc_b ? ACC_B_IN : ACC_A_IN;
  assign DEV_SEL_OUT = instr.sel;

  ////////////////////////////////////////////////////////////////////////////
  // Ready inputs: three-stage synchroniser, change when stages two and three agree

  logic [ND-1:0] rdy_s1_q;
  logic [ND-1:0] rdy_s2_q;
  logic [ND-1:0] rdy_s3_q;
  logic [ND-1:0] rdy_q;
  logic [ND-1:0] rdy_rise;
  logic [ND-1:0] dev_mask;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rdy_s1_q <= '0;
      rdy_s2_q <= '0;
      rdy_s3_q <= '0;
      rdy_q    <= '0;
    end
    else
    begin
      rdy_s1_q <= DEV_READY_IN;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
      for (int i = 0; i < ND; i++)
      begin
        if (rdy_s2_q[i] == rdy_s3_q[i])
        begin
          rdy_q[i] <= rdy_s3_q[i];
        end
      end
    end
  end

  assign dev_mask = ~ND'(0) << ioiu_pkg::FIRST_DEV;
  assign rdy_rise = (rdy_s2_q & rdy_s3_q) & ~rdy_q & dev_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Device flags

  logic [ND-1:0] flag_q;
  logic [ND-1:0] flag_set;
  logic [ND-1:0] flag_clr;
  logic          op_flag;
  logic          flag_hc;

  assign op_flag = is_std && (instr.op == ioiu_pkg::OP_FLAG);
  // Ops whose bit 9 holds/clears the device flag
  assign flag_hc = is_std && instr.clr && !op_flag && !(sel_ovf && (instr.op == ioiu_pkg::OP_SKIP_CLR
                   || instr.op == ioiu_pkg::OP_SKIP_SET));
  assign flag_set = rdy_rise | ((op_flag && !instr.clr && !sel_sys && !sel_ovf) ? sel_hot : '0);
  assign flag_clr = ((op_flag && instr.clr && !sel_sys && !sel_ovf) || flag_hc) ? sel_hot : '0;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flag_q <= '0;
    end
    else
    begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits

  logic [ND-1:0] ctrl_q;
  logic          op_ctl;

  assign op_ctl = is_std && (instr.op == ioiu_pkg::OP_CONTROL);

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= '0;
    end
    else if (op_ctl && !instr.acc_b)
    begin
      ctrl_q <= ctrl_q | sel_hot;
    end
    else if (op_ctl && instr.acc_b)
    begin
      ctrl_q <= sel_sys ? '0 : (ctrl_q & ~sel_hot);
    end
  end

  assign DEV_CTRL_OUT = ctrl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable and overflow

  logic ien_q;
  logic ovf_q;
  logic ovf_skip;

  assign ovf_skip = is_std && sel_ovf && (instr.op == ioiu_pkg::OP_SKIP_CLR || instr.op == ioiu_pkg::OP_SKIP_SET);

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ien_q <= 1'b0;
    end
    else if (op_flag && sel_sys)
    begin
      ien_q <= !instr.clr;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ovf_q <= 1'b0;
    end
    else if (op_flag && sel_ovf)
    begin
      ovf_q <= !instr.clr;
    end
    else if (ovf_skip && instr.clr)
    begin
      ovf_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution results, one phase

  logic                         skip_d;
  ioiu_pkg::ioiu_acc_wr_t       acc_d;

  always_comb
  begin
    skip_d = 1'b0;
    acc_d  = '0;
    if (is_std)
    begin
      case (instr.op)
        ioiu_pkg::OP_SKIP_CLR:
        begin
          skip_d = sel_ovf ? !ovf_q : !flag_q[instr.sel];
        end
        ioiu_pkg::OP_SKIP_SET:
        begin
          skip_d = sel_ovf ? ovf_q : flag_q[instr.sel];
        end
        ioiu_pkg::OP_MERGE:
        begin
          acc_d = '{we: 1'b1, sel_b: instr.acc_b, data: acc_sel | DEV_RD_DATA_IN};
        end
        ioiu_pkg::OP_LOAD:
        begin
          acc_d = '{we: 1'b1, sel_b: instr.acc_b, data: DEV_RD_DATA_IN};
        end
        default:
        begin
          skip_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      DONE_OUT   <= 1'b0;
      SKIP_OUT   <= 1'b0;
      ACC_WR_OUT <= '0;
    end
    else
    begin
      DONE_OUT   <= INSTR_VALID_IN && (run_q == ioiu_pkg::RUNNING);
      SKIP_OUT   <= skip_d;
      ACC_WR_OUT <= acc_d;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      DEV_WR_OUT      <= 1'b0;
      DEV_WR_DATA_OUT <= '0;
    end
    else
    begin
      DEV_WR_OUT <= is_std && (instr.op == ioiu_pkg::OP_OUTPUT);
      if (is_std && (instr.op == ioiu_pkg::OP_OUTPUT))
      begin
        DEV_WR_DATA_OUT <= acc_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Halt

  logic run_cmd;

  assign run_cmd = REG_WR_IN && (REG_ADDR_IN == ioiu_pkg::REG_STATUS) && REG_WR_DATA_IN[ioiu_pkg::ST_HALTED];

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      run_q         <= ioiu_pkg::RUNNING;
      HALT_WORD_OUT <= '0;
      HALT_PC_OUT   <= '0;
    end
    else
    begin
      case (run_q)
        ioiu_pkg::RUNNING:
        begin
          if (is_std && (instr.op == ioiu_pkg::OP_HALT))
          begin
            run_q         <= ioiu_pkg::HALTED;
            HALT_WORD_OUT <= INSTR_WORD_IN;
            HALT_PC_OUT   <= INSTR_PC_IN + ioiu_pkg::PC_W'(1);
          end
        end
        ioiu_pkg::HALTED:
        begin
          if (run_cmd)
          begin
            run_q <= ioiu_pkg::RUNNING;
          end
        end
        default:
        begin
          run_q <= ioiu_pkg::RUNNING;
        end
      endcase
    end
  end

  assign HALT_OUT = (run_q == ioiu_pkg::HALTED);

  ////////////////////////////////////////////////////////////////////////////
  // Priority network and in-service tracking

  logic [ND-1:0]             svc_q;
  logic [ND-1:0]             req_vec;
  logic                      svc_any;
  logic [ioiu_pkg::SEL_W-1:0] svc_top;
  logic                      req_any;
  logic [ioiu_pkg::SEL_W-1:0] req_top;

  ioiu_prio_enc #(
    .WIDTH (ND),
    .IDX_W (ioiu_pkg::SEL_W)
  ) u_svc_enc (
    .req_in    (svc_q),
    .valid_out (svc_any),
    .idx_out   (svc_top)
  );

  always_comb
  begin
    for (int i = 0; i < ND; i++)
    begin
      req_vec[i] = flag_q[i] && ctrl_q[i] && (!svc_any || (ioiu_pkg::SEL_W'(i) < svc_top));
    end
  end

  ioiu_prio_enc #(
    .WIDTH (ND),
    .IDX_W (ioiu_pkg::SEL_W)
  ) u_req_enc (
    .req_in    (req_vec),
    .valid_out (req_any),
    .idx_out   (req_top)
  );

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      svc_q <= '0;
    end
    else if (IRQ_ACK_IN && IRQ_REQ_OUT)
    begin
      svc_q <= svc_q | (ND'(1) << IRQ_CODE_OUT);
    end
    else if (SVC_END_IN && svc_any)
    begin
      svc_q <= svc_q & ~(ND'(1) << svc_top);
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      IRQ_REQ_OUT  <= 1'b0;
      IRQ_CODE_OUT <= '0;
    end
    else if (INSTR_VALID_IN || DONE_OUT)
    begin
      IRQ_REQ_OUT <= 1'b0;
    end
    else
    begin
      IRQ_REQ_OUT  <= req_any && ien_q && !HALT_OUT && !IRQ_ACK_IN;
      IRQ_CODE_OUT <= req_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge CLK_SYS_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      REG_RD_DATA_OUT <= '0;
    end
    else if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        ioiu_pkg::REG_STATUS:  REG_RD_DATA_OUT <= HW'({ovf_q, ien_q, HALT_OUT});
        ioiu_pkg::REG_FLAG_LO: REG_RD_DATA_OUT <= flag_q[HW-1:0];
        ioiu_pkg::REG_FLAG_HI: REG_RD_DATA_OUT <= flag_q[ND-1:HW];
        ioiu_pkg::REG_CTL_LO:  REG_RD_DATA_OUT <= ctrl_q[HW-1:0];
        ioiu_pkg::REG_CTL_HI:  REG_RD_DATA_OUT <= ctrl_q[ND-1:HW];
        ioiu_pkg::REG_SVC_LO:  REG_RD_DATA_OUT <= svc_q[HW-1:0];
        ioiu_pkg::REG_SVC_HI:  REG_RD_DATA_OUT <= svc_q[ND-1:HW];
        default:               REG_RD_DATA_OUT <= '0;
      endcase
    end
    else
    begin
      REG_RD_DATA_OUT <= '0;
    end
  end

endmodule
